// File: logic/sensor_spi_pkg.sv
// Purpose: shared constants for the angle sensor serial port, both ends
// Assumes: core clock of 250 MHz, serial mode 1, 16-bit frames
// Notes:   every frame field, address, reset value and timing count lives here

package sensor_spi_pkg;

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int PAR_BIT    = 15;
  localparam int RW_BIT     = 14;
  localparam int DATA_W     = 14;
  localparam int CNT_W      = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_SAT  = 5'h1f;

  // ---------------------------------------------------------------
  // register addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [13:0] ADDR_NOP      = 14'h0000;
  localparam logic [13:0] ADDR_ERR_REG  = 14'h0001;
  localparam logic [13:0] ADDR_PROG     = 14'h0003;
  localparam logic [13:0] ADDR_DIAG     = 14'h3ffc;
  localparam logic [13:0] ADDR_MAG      = 14'h3ffd;
  localparam logic [13:0] ADDR_ANG_RAW  = 14'h3ffe;
  localparam logic [13:0] ADDR_ANG_COMP = 14'h3fff;
  localparam logic [13:0] ADDR_NV_FIRST = 14'h0016;
  localparam logic [13:0] ADDR_NV_LAST  = 14'h001a;
  localparam int          NV_COUNT      = 5;
  localparam int          NV_SET1_IDX   = 2;
  localparam logic [13:0] NV_SET1_RESET = 14'h0001;
  localparam logic [13:0] REG_RESET     = 14'h0000;

  // error flag register bits
  localparam int ERR_W      = 3;
  localparam int ERR_PARITY = 2;
  localparam int ERR_BADCMD = 1;
  localparam int ERR_FRAME  = 0;

  // ---------------------------------------------------------------
  // timing, host side
  // ---------------------------------------------------------------
  localparam int CORE_PERIOD_NS  = 4;
  localparam int SCLK_MIN_PER_NS = 100;
  localparam int MISO_VALID_NS   = 51;
  localparam int LEAD_NS         = 350;
  localparam int GAP_NS          = 350;
  localparam int SYNC_STAGES     = 2;
  localparam int HALF_MIN_CYC    = (SCLK_MIN_PER_NS / 2 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int MISO_WAIT_CYC   = (MISO_VALID_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS + SYNC_STAGES + 1;
  localparam int HALF_CYC        = (MISO_WAIT_CYC > HALF_MIN_CYC) ? MISO_WAIT_CYC : HALF_MIN_CYC;
  localparam int LEAD_CYC        = (LEAD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int GAP_CYC         = (GAP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int TIMER_W         = 8;

endpackage : sensor_spi_pkg

// File: logic/sensor_spi_if.sv
// Purpose: four-wire serial link between host and sensor port
// Assumes: miso is released when miso_oe_n is high
// Notes:   a released miso reads as high, like a weak pull-up

`timescale 1ns/1ps

interface sensor_spi_if;
  logic sclk;
  logic select_low_active;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  logic miso_line;

  assign miso_line = miso_oe_n ? 1'b1 : miso;

  modport device (
    input  sclk,
    input  select_low_active,
    input  mosi,
    output miso,
    output miso_oe_n
  );

  modport host (
    output sclk,
    output select_low_active,
    output mosi,
    input  miso_line
  );
endinterface : sensor_spi_if

// File: logic/bit_sync.sv
// Purpose: two-flop synchroniser for a single level
// Assumes: input is a level from another clock domain or a pin
// Notes:   only the second stage may be read by logic

`timescale 1ns/1ps

module bit_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_level,
  output logic      o_level
);
  logic meta;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta    <= RESET_VAL;
      o_level <= RESET_VAL;
    end else begin
      meta    <= i_level;
      o_level <= meta;
    end
  end
endmodule : bit_sync

// File: logic/sensor_spi_device.sv
// Purpose: sensor side of the serial port: shifter on the link clock,
//          command execution and registers on the core clock
// Assumes: host keeps mode 1, holds select high at least 350 ns between
//          frames and never toggles the link clock outside a frame
// Notes:   link-side capture is quasi-static once select is high; the
//          core takes it only after a synchronised select rise

`timescale 1ns/1ps

module sensor_spi_device (
  input  wire logic    i_core_clk,
  input  wire logic    i_resetn,
  sensor_spi_if.device link,
  input  wire logic [13:0] i_diag_agc,
  input  wire logic [13:0] i_magnitude,
  input  wire logic [13:0] i_angle_raw,
  input  wire logic [13:0] i_angle_comp,
  output logic [13:0]      o_prog,
  output logic [13:0]      o_nv_regs [sensor_spi_pkg::NV_COUNT]
);

  // ---------------------------------------------------------------
  // link clock domain: receive shifter
  // ---------------------------------------------------------------
  logic                             fresh_fall;
  logic                             fresh_rise;
  logic [sensor_spi_pkg::CNT_W-1:0] frame_len;
  logic [sensor_spi_pkg::CNT_W-1:0] rise_idx;
  logic [15:0]                      frame_word;
  logic [15:0]                      tx_word;
  logic                             miso_bit;

  // select high arms a new frame without needing a clock edge
  always_ff @(negedge link.sclk or posedge link.select_low_active) begin
    if (link.select_low_active) begin
      fresh_fall <= 1'b1;
    end else begin
      fresh_fall <= 1'b0;
    end
  end

  always_ff @(negedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      frame_len <= '0;
    end else if (fresh_fall) begin
      frame_len <= 5'h01;
    end else if (frame_len != sensor_spi_pkg::CNT_SAT) begin
      frame_len <= frame_len + 5'h01;
    end
  end

  always_ff @(negedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      frame_word <= '0;
    end else begin
      frame_word <= {frame_word[14:0], link.mosi};
    end
  end

  // ---------------------------------------------------------------
  // link clock domain: transmit
  // ---------------------------------------------------------------
  always_ff @(posedge link.sclk or posedge link.select_low_active) begin
    if (link.select_low_active) begin
      fresh_rise <= 1'b1;
    end else begin
      fresh_rise <= 1'b0;
    end
  end

  always_ff @(posedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rise_idx <= '0;
    end else if (fresh_rise) begin
      rise_idx <= 5'h01;
    end else if (rise_idx != sensor_spi_pkg::CNT_SAT) begin
      rise_idx <= rise_idx + 5'h01;
    end
  end

  // leading edge launches, host takes it on the trailing edge
  always_ff @(posedge link.sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      miso_bit <= 1'b0;
    end else if (fresh_rise) begin
      miso_bit <= tx_word[15];
    end else if (rise_idx < sensor_spi_pkg::CNT_FULL) begin
      miso_bit <= tx_word[4'hf - rise_idx[3:0]];
    end else begin
      miso_bit <= 1'b0;
    end
  end

  assign link.miso      = miso_bit;
  assign link.miso_oe_n = link.select_low_active;

  // ---------------------------------------------------------------
  // core domain: frame end detection
  // ---------------------------------------------------------------
  logic select_sync;
  logic select_prev;
  logic frame_end;

  bit_sync #(
    .RESET_VAL (1'b1)
  ) u_select_sync (
    .i_clk    (i_core_clk),
    .i_resetn (i_resetn),
    .i_level  (link.select_low_active),
    .o_level  (select_sync)
  );

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      select_prev <= 1'b1;
    end else begin
      select_prev <= select_sync;
    end
  end

  assign frame_end = select_sync & ~select_prev;

  // ---------------------------------------------------------------
  // core domain: registers and decode
  // ---------------------------------------------------------------
  logic [sensor_spi_pkg::ERR_W-1:0] err_flags;
  logic [13:0]                      prog_reg;
  logic [13:0]                      nv_reg [sensor_spi_pkg::NV_COUNT];
  logic                             write_pending;
  logic [13:0]                      write_target;

  function automatic logic is_nv(input logic [13:0] addr);
    return (addr >= sensor_spi_pkg::ADDR_NV_FIRST) && (addr <= sensor_spi_pkg::ADDR_NV_LAST);
  endfunction : is_nv

  function automatic logic addr_valid(input logic [13:0] addr);
    return (addr == sensor_spi_pkg::ADDR_NOP) || (addr == sensor_spi_pkg::ADDR_ERR_REG) ||
           (addr == sensor_spi_pkg::ADDR_PROG) || (addr >= sensor_spi_pkg::ADDR_DIAG) || is_nv(addr);
  endfunction : addr_valid

  function automatic logic [13:0] read_value(input logic [13:0] addr);
    logic [13:0] nv_off;
    nv_off = addr - sensor_spi_pkg::ADDR_NV_FIRST;
    if (addr == sensor_spi_pkg::ADDR_ERR_REG) begin
      return {11'h000, err_flags};
    end else if (addr == sensor_spi_pkg::ADDR_PROG) begin
      return prog_reg;
    end else if (addr == sensor_spi_pkg::ADDR_DIAG) begin
      return i_diag_agc;
    end else if (addr == sensor_spi_pkg::ADDR_MAG) begin
      return i_magnitude;
    end else if (addr == sensor_spi_pkg::ADDR_ANG_RAW) begin
      return i_angle_raw;
    end else if (addr == sensor_spi_pkg::ADDR_ANG_COMP) begin
      return i_angle_comp;
    end else if (is_nv(addr)) begin
      return nv_reg[nv_off[2:0]];
    end else begin
      return sensor_spi_pkg::REG_RESET;
    end
  endfunction : read_value

  // ---------------------------------------------------------------
  // core domain: command execution at frame end
  // ---------------------------------------------------------------
  logic [sensor_spi_pkg::ERR_W-1:0] new_err;
  logic [sensor_spi_pkg::ERR_W-1:0] next_err;
  logic [13:0]                      next_tx_data;
  logic                             next_pending;
  logic [13:0]                      next_target;
  logic                             write_go;
  logic                             clear_err;
  logic [13:0]                      cmd_addr;

  assign cmd_addr = frame_word[13:0];

  always_comb begin
    new_err      = '0;
    next_tx_data = tx_word[13:0];
    next_pending = write_pending;
    next_target  = write_target;
    write_go     = 1'b0;
    clear_err    = 1'b0;
    if (frame_len != sensor_spi_pkg::CNT_FULL) begin
      new_err[sensor_spi_pkg::ERR_FRAME] = 1'b1;
    end else if (^frame_word) begin
      new_err[sensor_spi_pkg::ERR_PARITY] = 1'b1;
      next_pending                        = 1'b0;
    end else if (write_pending) begin
      // data frame of a write; a read-only target swallows it
      write_go     = 1'b1;
      next_pending = 1'b0;
      next_tx_data = frame_word[13:0];
      if (!(write_target == sensor_spi_pkg::ADDR_PROG || is_nv(write_target))) begin
        next_tx_data = read_value(write_target);
      end
    end else if (!addr_valid(cmd_addr)) begin
      new_err[sensor_spi_pkg::ERR_BADCMD] = 1'b1;
    end else if (frame_word[sensor_spi_pkg::RW_BIT]) begin
      next_tx_data = read_value(cmd_addr);
      clear_err    = (cmd_addr == sensor_spi_pkg::ADDR_ERR_REG);
    end else begin
      next_pending = 1'b1;
      next_target  = cmd_addr;
      next_tx_data = read_value(cmd_addr);
    end
    // a fault seen in the same frame survives the clearing read
    next_err = (clear_err ? '0 : err_flags) | new_err;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      err_flags <= '0;
    end else if (frame_end) begin
      err_flags <= next_err;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      write_pending <= 1'b0;
      write_target  <= sensor_spi_pkg::REG_RESET;
    end else if (frame_end) begin
      write_pending <= next_pending;
      write_target  <= next_target;
    end
  end

  // outgoing frame stays still for the whole next frame
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_word <= '0;
    end else if (frame_end) begin
      tx_word <= {^{|new_err, next_tx_data}, |new_err, next_tx_data};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prog_reg <= sensor_spi_pkg::REG_RESET;
    end else if (frame_end && write_go && write_target == sensor_spi_pkg::ADDR_PROG) begin
      prog_reg <= frame_word[13:0];
    end
  end

  generate
    for (genvar g = 0; g < sensor_spi_pkg::NV_COUNT; g++) begin : g_nv
      localparam logic [13:0] NV_ADDR = sensor_spi_pkg::ADDR_NV_FIRST + 14'(g);
      localparam logic [13:0] NV_INIT = (g == sensor_spi_pkg::NV_SET1_IDX) ?
                                        sensor_spi_pkg::NV_SET1_RESET : sensor_spi_pkg::REG_RESET;
      always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          nv_reg[g] <= NV_INIT;
        end else if (frame_end && write_go && write_target == NV_ADDR) begin
          nv_reg[g] <= frame_word[13:0];
        end
      end
      assign o_nv_regs[g] = nv_reg[g];
    end
  endgenerate

  assign o_prog = prog_reg;

endmodule : sensor_spi_device

// File: logic/sensor_spi_host.sv
// Purpose: host end of the sensor serial port; makes the link clock
// Assumes: one request per frame; caller sequences command and data frames
// Notes:   link clock divided from the core clock, well under 10 MHz

`timescale 1ns/1ps

module sensor_spi_host (
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  sensor_spi_if.host       link,
  input  wire logic        i_req_valid,
  output logic             o_req_ready,
  input  wire logic        i_req_data_frame,
  input  wire logic        i_req_read,
  input  wire logic [13:0] i_req_field,
  output logic             o_resp_valid,
  output logic [15:0]      o_resp_word,
  output logic             o_resp_parity_ok,
  output logic             o_resp_error_flag
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_HIGH = 3'b010,
    ST_LOW  = 3'b011,
    ST_GAP  = 3'b100
  } host_state_e;

  host_state_e                        state;
  logic [sensor_spi_pkg::TIMER_W-1:0] timer;
  logic [sensor_spi_pkg::CNT_W-1:0]   bits;
  logic [15:0]                        tx_sh;
  logic [15:0]                        rx_sh;
  logic                               miso_sync;
  logic [14:0]                        low15;
  logic                               tick;
  logic                               take;
  logic                               last_low;

  localparam logic [7:0] HALF_T = 8'(sensor_spi_pkg::HALF_CYC - 1);
  localparam logic [7:0] LEAD_T = 8'(sensor_spi_pkg::LEAD_CYC - 1);
  localparam logic [7:0] GAP_T  = 8'(sensor_spi_pkg::GAP_CYC - 1);

  bit_sync #(
    .RESET_VAL (1'b1)
  ) u_miso_sync (
    .i_clk    (i_core_clk),
    .i_resetn (i_resetn),
    .i_level  (link.miso_line),
    .o_level  (miso_sync)
  );

  assign o_req_ready = (state == ST_IDLE);
  assign take        = i_req_valid & o_req_ready;
  assign tick        = (timer == '0);
  assign last_low    = (state == ST_LOW) & tick & (bits == sensor_spi_pkg::CNT_FULL);
  // write data frames carry a zero in the read bit position
  assign low15       = {i_req_read & ~i_req_data_frame, i_req_field};

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
      timer <= '0;
      bits  <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take) begin
            state <= ST_LEAD;
            timer <= LEAD_T;
            bits  <= '0;
          end
        end
        ST_LEAD, ST_LOW: begin
          if (!tick) begin
            timer <= timer - 8'h01;
          end else if (last_low) begin
            state <= ST_GAP;
            timer <= GAP_T;
          end else begin
            state <= ST_HIGH;
            timer <= HALF_T;
          end
        end
        ST_HIGH: begin
          if (!tick) begin
            timer <= timer - 8'h01;
          end else begin
            state <= ST_LOW;
            timer <= HALF_T;
            bits  <= bits + 5'h01;
          end
        end
        ST_GAP: begin
          if (!tick) begin
            timer <= timer - 8'h01;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // link pins
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      link.select_low_active <= 1'b1;
      link.sclk              <= 1'b0;
    end else begin
      if (take) begin
        link.select_low_active <= 1'b0;
      end else if (last_low) begin
        link.select_low_active <= 1'b1;
      end
      if ((state == ST_LEAD || state == ST_LOW) && tick && !last_low) begin
        link.sclk <= 1'b1;
      end else if (state == ST_HIGH && tick) begin
        link.sclk <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_sh     <= '0;
      link.mosi <= 1'b0;
    end else if (take) begin
      tx_sh <= {^low15, low15};
    end else if ((state == ST_LEAD || state == ST_LOW) && tick && !last_low) begin
      link.mosi <= tx_sh[15];
      tx_sh     <= {tx_sh[14:0], 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // receive and answer
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_sh <= '0;
    end else if (state == ST_HIGH && tick) begin
      rx_sh <= {rx_sh[14:0], miso_sync};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_resp_valid      <= 1'b0;
      o_resp_word       <= '0;
      o_resp_parity_ok  <= 1'b0;
      o_resp_error_flag <= 1'b0;
    end else begin
      o_resp_valid <= last_low;
      if (last_low) begin
        o_resp_word       <= rx_sh;
        o_resp_parity_ok  <= ~^rx_sh;
        o_resp_error_flag <= rx_sh[sensor_spi_pkg::RW_BIT];
      end
    end
  end

endmodule : sensor_spi_host

// File: verif/sensor_spi_props.sv
// Purpose: link checks between the host and device ends
// Assumes: host derives sclk from the core clock, so core sampling is exact
// Notes:   watches the first link only; the bench drives the second itself
`timescale 1ns/1ps

module sensor_spi_props (
  input  wire logic i_core_clk,
  input  wire logic i_resetn,
  input  wire logic sclk,
  input  wire logic select_low_active,
  input  wire logic mosi,
  input  wire logic miso,
  input  wire logic miso_oe_n,
  input  wire logic miso_line
);
  logic       sclk_q;
  logic [4:0] rises;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end

  // cleared while deselected so a short frame cannot borrow old counts
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) rises <= 5'h00;
    else if (select_low_active) rises <= 5'h00;
    else if (sclk && !sclk_q) rises <= rises + 5'h01;
  end

  a_oe_tracks_sel: assert property (miso_oe_n == select_low_active)
    else $error("miso enable differs from select");
  a_line_released: assert property (select_low_active |-> miso_line)
    else $error("miso not released while deselected");
  a_idle_clk_low: assert property (select_low_active |-> !sclk)
    else $error("sclk moves outside a frame");
  a_frame_start: assert property ($fell(select_low_active) |-> !sclk [*8])
    else $error("sclk not low at frame start");
  a_high_width: assert property ($rose(sclk) |-> sclk [*8])
    else $error("sclk high phase too short");
  a_low_width: assert property ($fell(sclk) && !select_low_active |-> !sclk [*8])
    else $error("sclk low phase too short");
  a_sixteen_clocks: assert property ($rose(select_low_active) |-> rises == 5'h10)
    else $error("frame without sixteen clocks");
  a_mosi_held: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi moves while sclk high");
  a_miso_held: assert property (!sclk && !$past(sclk) && !select_low_active && !$past(select_low_active)
    |-> $stable(miso))
    else $error("miso moves while sclk low");

  cover property ($rose(select_low_active) && rises == 5'h10);
  cover property (!select_low_active && !miso_line);
  cover property ($fell(select_low_active));
endmodule : sensor_spi_props

// File: verif/angle_sensor_spi_slave_tb_top.sv
// Purpose: host and device back to back, plus a second device driven raw
// Assumes: raw link clock of 125 ns made here, only inside frames
// Notes:   model predicts each answer word one frame ahead; after a bad command only its error flag and parity are checked
`timescale 1ns/1ps

module angle_sensor_spi_slave_tb_top;
  logic        i_core_clk = 1'b0;
  logic        i_resetn   = 1'b0;
  logic        rv = 1'b0, df = 1'b0, rd = 1'b0;
  logic [13:0] fld = 14'h0000;
  logic        rdy, vld, pok, efl;
  logic [15:0] word, r;
  logic [13:0] agc, mag, araw, acomp, prog;
  logic [13:0] nv [5];
  logic [31:0] seed = 32'h7029;
  int          n_fail = 0;
  int          n_tests = 0;
  logic [13:0] m_prog = 14'h0000, m_addr = 14'h0000;
  logic [13:0] m_nv [5] = '{14'h0000, 14'h0000, 14'h0001, 14'h0000, 14'h0000};
  logic [2:0]  m_err = 3'h0;
  logic [15:0] m_exp = 16'h0000;
  logic        m_known = 1'b1;
  logic [13:0] tbl [13] = '{14'h0000, 14'h0001, 14'h0003, 14'h0016, 14'h0017, 14'h0018, 14'h0019,
                            14'h001a, 14'h3ffc, 14'h3ffd, 14'h3ffe, 14'h3fff, 14'h0002};

  sensor_spi_if lk ();
  sensor_spi_if lk2 ();

  always #2 i_core_clk = ~i_core_clk;

  sensor_spi_host sensor_spi_host_inst (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .link(lk.host),
    .i_req_valid(rv), .o_req_ready(rdy), .i_req_data_frame(df), .i_req_read(rd), .i_req_field(fld),
    .o_resp_valid(vld), .o_resp_word(word), .o_resp_parity_ok(pok), .o_resp_error_flag(efl));
  sensor_spi_device sensor_spi_device_inst (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .link(lk.device),
    .i_diag_agc(agc), .i_magnitude(mag), .i_angle_raw(araw), .i_angle_comp(acomp), .o_prog(prog), .o_nv_regs(nv));
  sensor_spi_device sensor_spi_device_inst2 (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .link(lk2.device),
    .i_diag_agc(agc), .i_magnitude(mag), .i_angle_raw(araw), .i_angle_comp(acomp), .o_prog(), .o_nv_regs());
  sensor_spi_props sensor_spi_props_inst (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .sclk(lk.sclk),
    .select_low_active(lk.select_low_active), .mosi(lk.mosi), .miso(lk.miso), .miso_oe_n(lk.miso_oe_n),
    .miso_line(lk.miso_line));

  // ---------------------------------------------------------------
  // model and helpers
  // ---------------------------------------------------------------
  function automatic logic [13:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[13:0];
  endfunction : rnd

  function automatic logic [15:0] fw(input logic e, input logic [13:0] d);
    return {^{e, d}, e, d};
  endfunction : fw

  function automatic logic is_nv(input logic [13:0] a);
    return a >= 14'h0016 && a <= 14'h001a;
  endfunction : is_nv

  function automatic logic [13:0] rdv(input logic [13:0] a);
    case (a)
      14'h0001: return {11'h000, m_err};
      14'h0003: return m_prog;
      14'h3ffc: return agc;
      14'h3ffd: return mag;
      14'h3ffe: return araw;
      14'h3fff: return acomp;
      default:  return is_nv(a) ? m_nv[a - 14'h0016] : 14'h0000;
    endcase
  endfunction : rdv

  task automatic results();
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic [17:0] g, input logic [17:0] e, input logic [17:0] m);
    n_tests++;
    if ((g & m) !== (e & m)) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g & m, e & m);
    end
  endtask : chk

  task automatic xfer(input logic d, input logic rw, input logic [13:0] f);
    int k;
    for (k = 0; k < 300 && !rdy; k++) @(negedge i_core_clk);
    if (!rdy) begin n_fail++; results(); end
    rv = 1'b1; df = d; rd = rw; fld = f;
    @(negedge i_core_clk);
    rv = 1'b0;
    for (k = 0; k < 800 && !vld; k++) @(negedge i_core_clk);
    if (!vld) begin n_fail++; results(); end
    chk({pok, efl, word}, {1'b1, m_exp[14], m_exp}, {2'b11, m_known ? 16'hffff : 16'h4000});
    m_known = 1'b1;
    if (d) begin
      if (m_addr == 14'h0003) m_prog = f;
      else if (is_nv(m_addr)) m_nv[m_addr - 14'h0016] = f;
      m_exp = fw(1'b0, rdv(m_addr));
    end else if (!(f < 14'h0004 && f != 14'h0002) && !is_nv(f) && f < 14'h3ffc) begin
      m_err[1] = 1'b1;
      m_exp = fw(1'b1, 14'h0000);
      m_known = 1'b0;
    end else begin
      m_exp = fw(1'b0, rdv(f));
      m_addr = f;
      if (rw && f == 14'h0001) m_err = 3'h0;
    end
  endtask : xfer

  // bench stands in for the host: clock still and select high between frames
  task automatic raw(input logic [15:0] w, input int n, output logic [15:0] q);
    q = 16'h0000;
    lk2.select_low_active = 1'b0;
    #400;
    for (int i = 0; i < n; i++) begin
      lk2.sclk = 1'b1;
      lk2.mosi = w[15 - i];
      #62.5;
      lk2.sclk = 1'b0;
      q = {q[14:0], lk2.miso_line};
      #62.5;
    end
    lk2.select_low_active = 1'b1;
    #400;
  endtask : raw

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int i;
    logic rr;
    lk2.sclk = 1'b0;
    lk2.select_low_active = 1'b1;
    lk2.mosi = 1'b0;
    agc = rnd();
    mag = rnd();
    araw = rnd();
    acomp = rnd();
    repeat (20) @(negedge i_core_clk);
    i_resetn = 1'b1;
    xfer(1'b0, 1'b0, 14'h0003);
    xfer(1'b1, 1'b0, 14'h2a5c);
    xfer(1'b0, 1'b1, 14'h0003);
    xfer(1'b0, 1'b1, 14'h0002);
    xfer(1'b0, 1'b1, 14'h0001);
    xfer(1'b0, 1'b1, 14'h0000);
    for (int k = 0; k < 30; k++) begin
      i = rnd() % 13;
      rr = ^rnd() || i == 12;
      xfer(1'b0, rr, tbl[i]);
      if (!rr) xfer(1'b1, 1'b0, rnd());
    end
    raw(16'h4001, 15, r);
    raw(16'h4001, 16, r);
    chk({2'b00, r}, 18'h04000, 18'h04000);
    raw(16'hc000, 16, r);
    chk({2'b00, r}, 18'h08001, 18'h3ffff);
    raw(16'h4000, 16, r);
    raw(16'h4001, 16, r);
    chk({2'b00, r}, 18'h04000, 18'h04000);
    raw(16'hc000, 16, r);
    chk({2'b00, r}, 18'h08004, 18'h3ffff);
    chk({4'h0, prog}, {4'h0, m_prog}, 18'h3ffff);
    for (int k = 0; k < 5; k++) chk({4'h0, nv[k]}, {4'h0, m_nv[k]}, 18'h3ffff);
    results();
  end
endmodule : angle_sensor_spi_slave_tb_top
